// ### io_port_map.vh
/*
 * Register offsets, field positions and reset values of the eight-pin I/O port.
 * Assumes inclusion by the port logic and by verification code, with no other state.
 */
`ifndef IO_PORT_MAP_VH
`define IO_PORT_MAP_VH

// ----------------------------------------------------------------
// Port-wide registers (byte addresses)
// ----------------------------------------------------------------
`define OFS_DATA_OUT 12'h000
`define OFS_PIN_STATE 12'h004
`define OFS_DRIVE0 12'h008
`define OFS_DRIVE1 12'h00C
`define OFS_DRIVE2 12'h010
`define OFS_EDGE_RATE 12'h014
`define OFS_BIDIR_EN 12'h018
`define OFS_INBUF_DIS 12'h01C
`define OFS_BYPASS 12'h020
`define OFS_PORT_CFG 12'h024
`define OFS_IRQ_TYPE_LO 12'h028
`define OFS_IRQ_TYPE_HI 12'h02C
`define OFS_IRQ_STATUS 12'h030
`define OFS_REG_OUT_EN 12'h034
`define OFS_OE_SEL0 12'h038
`define OFS_OE_SEL1 12'h03C
`define OFS_SIO_CFG 12'h040
`define OFS_PIN_VIEW 12'h080

// ----------------------------------------------------------------
// Pin-view fields
// ----------------------------------------------------------------
`define PV_DATA 0
`define PV_STATE 1
`define PV_DRV_LO 2
`define PV_DRV_HI 4
`define PV_RATE 5
`define PV_BIDIR 6
`define PV_INDIS 7

// ----------------------------------------------------------------
// Port config fields
// ----------------------------------------------------------------
`define CFG_LVTTL 0

// ----------------------------------------------------------------
// Special pin pair config: per pair 4 bits (thr[1:0], analog, hyst)
// ----------------------------------------------------------------
`define SIO_PAIR_W 4
`define SIO_THR_LO 0
`define SIO_ANALOG 2
`define SIO_HYST 3

// ----------------------------------------------------------------
// Drive codes and interrupt types
// ----------------------------------------------------------------
`define DM_HIZ_ANALOG 3'h0
`define DM_HIZ_DIGITAL 3'h1
`define DM_RES_UP 3'h2
`define DM_RES_DOWN 3'h3
`define DM_OD_LOW 3'h4
`define DM_OD_HIGH 3'h5
`define DM_STRONG 3'h6
`define DM_RES_BOTH 3'h7
`define IRQ_NONE 2'h0
`define IRQ_RISE 2'h1
`define IRQ_FALL 2'h2
`define IRQ_BOTH 2'h3

`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000

`endif

// ### port_irq_unit.v
/*
 * Edge-detecting interrupt unit for one eight-pin port with sticky status.
 * Assumes pin levels already passed two flip-flops and a free-running clock in sleep.
 */
`timescale 1ns/100ps
`default_nettype none
`include "io_port_map.vh"

module port_irq_unit (
    input wire clock_i,
    input wire rst_n_i,
    input wire [7:0] pin_sync_i,
    input wire [15:0] irq_type_i,
    input wire [7:0] clear_i,
    output wire [7:0] status_o,
    output wire irq_o
);

    reg [7:0] prev_ff;
    reg [7:0] status_ff;
    wire [7:0] hit;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_ff <= `RST_BYTE;
        end else begin
            prev_ff <= pin_sync_i;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin edge detection
    // ----------------------------------------------------------------
    // Only edges are seen; a held level raises nothing.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : edge_det
            wire rise = pin_sync_i[g] & ~prev_ff[g];
            wire fall = ~pin_sync_i[g] & prev_ff[g];
            assign hit[g] = (irq_type_i[2*g+1:2*g] == `IRQ_RISE & rise) |
                (irq_type_i[2*g+1:2*g] == `IRQ_FALL & fall) |
                (irq_type_i[2*g+1:2*g] == `IRQ_BOTH & (rise | fall));
        end
    endgenerate

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_ff <= `RST_BYTE;
        end else begin
            status_ff <= (status_ff & ~clear_i) | hit;
        end
    end

    assign status_o = status_ff;
    assign irq_o = |status_ff;

endmodule
`default_nettype wire

// ### io_port.v
/*
 * Eight-pin configurable I/O port with APB register access and a port interrupt unit.
 * Assumes an APB master on clock_i, pad cells that honour drive, pull and slew controls,
 * and an auxiliary bus of output enables from the same clock domain.
 */
// Chosen here: the APB register port and the address map.
// Notes on behaviour
// - Strong mode drives pin high for data one, low for data zero.
// - Combined resistive mode pulls up on one, pulls down on zero.
// - Resistive modes unavailable on special pins in regulated output mode.
// - Every configuration register has a port-wide view; one bit per pin except port config, interrupt type, enable select and pair config.
// - Per-pin view gathers eight bits of one pin; both views share state.
// - Bidirectional pins switch between digital input and drive from aux enable.
// - Per-pin fast or slow edge rate, only in strong and open-drain modes.
// - All eight pins feed one port interrupt unit with own request.
// - Each pin interrupts on rising, falling, both edges, or none.
// - A configured edge sets the pin status bit and raises a request.
// - Edge detection keeps running in every sleep mode.
// - No level-sensitive detection; outside logic provides that.
// - Port selects CMOS or LVTTL thresholds; all buffers have hysteresis.
// - Each pin input buffer can be disabled in any drive mode.
// - Each special pin selects supply-level or regulated high output.
// - Special pin pairs share a reference setting one of four thresholds.
// - Pair reference may use the analog global line, forming comparators.
// - Hysteresis selectable on special pin input buffers.
// - Drive mode is a 3-bit code, 0 to 7 as listed.
// - During reset every pin is high impedance analog.
`timescale 1ns/100ps
`default_nettype none
`include "io_port_map.vh"

module io_port (
    input wire clock_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire [7:0] pin_in_i,
    output wire [7:0] pin_out_o,
    output wire [7:0] pin_oe_n_o,
    output wire [7:0] pull_up_en_o,
    output wire [7:0] pull_down_en_o,
    output wire [7:0] slow_rate_o,
    output wire [7:0] in_buf_en_o,
    output wire lvttl_sel_o,
    output wire [7:0] reg_out_en_o,
    output wire [7:0] pair_thr_sel_o,
    output wire [3:0] pair_analog_ref_o,
    output wire [3:0] pair_hyst_en_o,
    input wire [15:0] aux_oe_i,
    input wire [7:0] sys_out_i,
    output wire [7:0] sys_in_o,
    output wire port_irq_o
);

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    reg [7:0] data_ff;
    reg [7:0] drv0_ff;
    reg [7:0] drv1_ff;
    reg [7:0] drv2_ff;
    reg [7:0] rate_ff;
    reg [7:0] bidir_ff;
    reg [7:0] indis_ff;
    reg [7:0] bypass_ff;
    reg lvttl_ff;
    reg [15:0] irq_type_ff;
    reg [7:0] regout_ff;
    reg [31:0] oe_sel_ff;
    reg [15:0] sio_ff;
    reg [7:0] meta_ff;
    reg [7:0] sync_ff;
    reg [7:0] nxt_clear;
    wire [7:0] irq_status;

    wire wr_en = psel_i & penable_i & pwrite_i;
    wire pin_view_hit = ((paddr_i & 12'hFE0) == `OFS_PIN_VIEW);
    wire [2:0] pin_idx = paddr_i[4:2];
    wire known = pin_view_hit |
        (paddr_i <= `OFS_SIO_CFG && paddr_i[1:0] == 2'h0);

    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~known;

    // ----------------------------------------------------------------
    // Register writes; both views land on the same flip-flops
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_ff <= `RST_BYTE;
            drv0_ff <= `RST_BYTE;
            drv1_ff <= `RST_BYTE;
            drv2_ff <= `RST_BYTE;
            rate_ff <= `RST_BYTE;
            bidir_ff <= `RST_BYTE;
            indis_ff <= `RST_BYTE;
            bypass_ff <= `RST_BYTE;
            lvttl_ff <= 1'b0;
            irq_type_ff <= 16'h0000;
            regout_ff <= `RST_BYTE;
            oe_sel_ff <= `RST_WORD;
            sio_ff <= 16'h0000;
        end else if (wr_en && pin_view_hit) begin
            data_ff[pin_idx] <= pwdata_i[`PV_DATA];
            drv0_ff[pin_idx] <= pwdata_i[`PV_DRV_LO];
            drv1_ff[pin_idx] <= pwdata_i[`PV_DRV_LO+1];
            drv2_ff[pin_idx] <= pwdata_i[`PV_DRV_HI];
            rate_ff[pin_idx] <= pwdata_i[`PV_RATE];
            bidir_ff[pin_idx] <= pwdata_i[`PV_BIDIR];
            indis_ff[pin_idx] <= pwdata_i[`PV_INDIS];
        end else if (wr_en) begin
            case (paddr_i)
                `OFS_DATA_OUT: data_ff <= pwdata_i[7:0];
                `OFS_DRIVE0: drv0_ff <= pwdata_i[7:0];
                `OFS_DRIVE1: drv1_ff <= pwdata_i[7:0];
                `OFS_DRIVE2: drv2_ff <= pwdata_i[7:0];
                `OFS_EDGE_RATE: rate_ff <= pwdata_i[7:0];
                `OFS_BIDIR_EN: bidir_ff <= pwdata_i[7:0];
                `OFS_INBUF_DIS: indis_ff <= pwdata_i[7:0];
                `OFS_BYPASS: bypass_ff <= pwdata_i[7:0];
                `OFS_PORT_CFG: lvttl_ff <= pwdata_i[`CFG_LVTTL];
                `OFS_IRQ_TYPE_LO: irq_type_ff[7:0] <= pwdata_i[7:0];
                `OFS_IRQ_TYPE_HI: irq_type_ff[15:8] <= pwdata_i[7:0];
                `OFS_REG_OUT_EN: regout_ff <= pwdata_i[7:0];
                `OFS_OE_SEL0: oe_sel_ff[15:0] <= pwdata_i[15:0];
                `OFS_OE_SEL1: oe_sel_ff[31:16] <= pwdata_i[15:0];
                `OFS_SIO_CFG: sio_ff <= pwdata_i[15:0];
                default: data_ff <= data_ff;
            endcase
        end
    end

    // Status is write-one-to-clear; a new edge in the same cycle still wins.
    always @* begin
        nxt_clear = 8'h00;
        if (wr_en && paddr_i == `OFS_IRQ_STATUS) begin
            nxt_clear = pwdata_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Pin input synchroniser
    // ----------------------------------------------------------------
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= `RST_BYTE;
            sync_ff <= `RST_BYTE;
        end else begin
            meta_ff <= pin_in_i;
            sync_ff <= meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Per-pin drive logic
    // ----------------------------------------------------------------
    // The pad is told to drive and pull separately; a pull never fights a drive
    // because each mode enables at most one of them per data value.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : pin
            wire [2:0] dm = {drv2_ff[g], drv1_ff[g], drv0_ff[g]};
            wire [3:0] sel = oe_sel_ff[4*g+3:4*g];
            wire d = bypass_ff[g] ? sys_out_i[g] : data_ff[g];
            wire aux_en = aux_oe_i[sel];
            wire out_on = ~bidir_ff[g] | aux_en;
            wire res_ok = ~regout_ff[g];
            reg drive;
            reg pu;
            reg pd;
            always @* begin
                drive = 1'b0;
                pu = 1'b0;
                pd = 1'b0;
                case (dm)
                    `DM_HIZ_ANALOG: drive = 1'b0;
                    `DM_HIZ_DIGITAL: drive = 1'b0;
                    `DM_RES_UP: begin
                        drive = ~d;
                        pu = d & res_ok;
                    end
                    `DM_RES_DOWN: begin
                        drive = d;
                        pd = ~d & res_ok;
                    end
                    `DM_OD_LOW: drive = ~d;
                    `DM_OD_HIGH: drive = d;
                    `DM_STRONG: drive = 1'b1;
                    `DM_RES_BOTH: begin
                        pu = d & res_ok;
                        pd = ~d & res_ok;
                    end
                    default: drive = 1'b0;
                endcase
            end
            assign pin_out_o[g] = d;
            assign pin_oe_n_o[g] = ~(drive & out_on);
            assign pull_up_en_o[g] = pu & out_on;
            assign pull_down_en_o[g] = pd & out_on;
            // Edge rate means nothing to a resistor, so it is held fast there.
            assign slow_rate_o[g] = rate_ff[g] & (dm[2] & (dm != `DM_RES_BOTH));
            assign in_buf_en_o[g] = (dm != `DM_HIZ_ANALOG) & ~indis_ff[g];
        end
    endgenerate

    assign lvttl_sel_o = lvttl_ff;
    assign reg_out_en_o = regout_ff;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pair
            assign pair_thr_sel_o[2*g+1:2*g] =
                sio_ff[`SIO_PAIR_W*g+`SIO_THR_LO+1:`SIO_PAIR_W*g+`SIO_THR_LO];
            assign pair_analog_ref_o[g] = sio_ff[`SIO_PAIR_W*g+`SIO_ANALOG];
            assign pair_hyst_en_o[g] = sio_ff[`SIO_PAIR_W*g+`SIO_HYST];
        end
    endgenerate

    assign sys_in_o = sync_ff & in_buf_en_o;

    port_irq_unit irq_unit (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .pin_sync_i(sync_ff),
        .irq_type_i(irq_type_ff),
        .clear_i(nxt_clear),
        .status_o(irq_status),
        .irq_o(port_irq_o)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        prdata_o = `RST_WORD;
        if (pin_view_hit) begin
            prdata_o[`PV_DATA] = data_ff[pin_idx];
            prdata_o[`PV_STATE] = sync_ff[pin_idx];
            prdata_o[`PV_DRV_LO] = drv0_ff[pin_idx];
            prdata_o[`PV_DRV_LO+1] = drv1_ff[pin_idx];
            prdata_o[`PV_DRV_HI] = drv2_ff[pin_idx];
            prdata_o[`PV_RATE] = rate_ff[pin_idx];
            prdata_o[`PV_BIDIR] = bidir_ff[pin_idx];
            prdata_o[`PV_INDIS] = indis_ff[pin_idx];
        end else begin
            case (paddr_i)
                `OFS_DATA_OUT: prdata_o[7:0] = data_ff;
                `OFS_PIN_STATE: prdata_o[7:0] = sync_ff;
                `OFS_DRIVE0: prdata_o[7:0] = drv0_ff;
                `OFS_DRIVE1: prdata_o[7:0] = drv1_ff;
                `OFS_DRIVE2: prdata_o[7:0] = drv2_ff;
                `OFS_EDGE_RATE: prdata_o[7:0] = rate_ff;
                `OFS_BIDIR_EN: prdata_o[7:0] = bidir_ff;
                `OFS_INBUF_DIS: prdata_o[7:0] = indis_ff;
                `OFS_BYPASS: prdata_o[7:0] = bypass_ff;
                `OFS_PORT_CFG: prdata_o[0] = lvttl_ff;
                `OFS_IRQ_TYPE_LO: prdata_o[7:0] = irq_type_ff[7:0];
                `OFS_IRQ_TYPE_HI: prdata_o[7:0] = irq_type_ff[15:8];
                `OFS_IRQ_STATUS: prdata_o[7:0] = irq_status;
                `OFS_REG_OUT_EN: prdata_o[7:0] = regout_ff;
                `OFS_OE_SEL0: prdata_o[15:0] = oe_sel_ff[15:0];
                `OFS_OE_SEL1: prdata_o[15:0] = oe_sel_ff[31:16];
                `OFS_SIO_CFG: prdata_o[15:0] = sio_ff;
                default: prdata_o = `RST_WORD;
            endcase
        end
    end

endmodule
`default_nettype wire

// ### pad_model.sv
/* Model of the circuits outside the port pads.
   Assumes the bench sets its own drive after rising edges of clock_i. */
`timescale 1ns/100ps
`default_nettype none
module pad_model (
    input wire logic clock_i,
    input wire logic [7:0] pin_out_i,
    input wire logic [7:0] oe_n_i,
    input wire logic [7:0] up_i,
    input wire logic [7:0] dn_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pad_o
);
    logic [7:0] float_ff = 8'h00;
    // A pad that nobody drives flips each cycle, so no test can lean on a held level.
    always @(posedge clock_i) begin
        float_ff <= ~pad_o;
    end
    always_comb begin
        pad_o = (~oe_n_i & pin_out_i)
            | (oe_n_i & ext_en_i & ext_val_i)
            | (oe_n_i & ~ext_en_i & (up_i | (~dn_i & float_ff)));
    end
endmodule
`default_nettype wire

// ### io_port_checker.sv
/* Assertions on the pad controls and the port interrupt request.
   Assumes it is bound to io_port and shares its clock and reset. */
`timescale 1ns/100ps
`default_nettype none
`include "io_port_map.vh"
module io_port_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [7:0] pin_in_i,
    input wire logic [7:0] pin_out_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [7:0] pull_up_en_o,
    input wire logic [7:0] pull_down_en_o,
    input wire logic [7:0] slow_rate_o,
    input wire logic [7:0] in_buf_en_o,
    input wire logic [7:0] reg_out_en_o,
    input wire logic [7:0] sys_in_o,
    input wire logic port_irq_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------
    // Pad change history
    // ----------------------------------------
    logic [7:0] prev_ff;
    logic [4:0] chg_ff;
    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_ff <= 8'h00;
            chg_ff <= 5'h00;
        end else begin
            prev_ff <= pin_in_i;
            chg_ff <= {chg_ff[3:0], pin_in_i != prev_ff};
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_RESET_HIZ: assert property (disable iff (1'b0) !rst_n_i |-> pin_oe_n_o == 8'hFF
        && (pull_up_en_o | pull_down_en_o | in_buf_en_o) == 8'h00 && !port_irq_o)
        else $error("pins not in analog high impedance during reset");
    AST_PULL_EXCL: assert property ((pull_up_en_o & pull_down_en_o) == 8'h00)
        else $error("pull-up and pull-down on together");
    AST_PULL_LEVEL: assert property (((pull_up_en_o & ~pin_out_o)
        | (pull_down_en_o & pin_out_o)) == 8'h00) else $error("pull against data");
    AST_DRIVE_NO_PULL: assert property ((~pin_oe_n_o & (pull_up_en_o | pull_down_en_o)) == 8'h00)
        else $error("strong drive with a pull");
    AST_REG_NO_PULL: assert property ((reg_out_en_o & (pull_up_en_o | pull_down_en_o)) == 8'h00)
        else $error("pull on regulated pin");
    AST_SLOW_NOT_RES: assert property ((slow_rate_o & (pull_up_en_o | pull_down_en_o)) == 8'h00)
        else $error("slow edge in resistive drive");
    AST_INBUF_GATE: assert property ((sys_in_o & ~in_buf_en_o) == 8'h00)
        else $error("input seen through disabled buffer");
    AST_IRQ_HOLD: assert property (port_irq_o && !(psel_i && penable_i && pwrite_i
        && paddr_i == `OFS_IRQ_STATUS) |=> port_irq_o) else $error("request dropped uncleared");
    AST_IRQ_CAUSE: assert property ($rose(port_irq_o) |-> chg_ff != 5'h00)
        else $error("request without a pad change");
    cover property ($rose(port_irq_o));
    cover property (slow_rate_o == 8'hFF);
    cover property (pull_up_en_o != 8'h00 && pull_down_en_o != 8'h00);
endmodule
bind io_port io_port_checker chk (
    .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pin_in_i, .pin_out_o,
    .pin_oe_n_o, .pull_up_en_o, .pull_down_en_o, .slow_rate_o, .in_buf_en_o, .reg_out_en_o,
    .sys_in_o, .port_irq_o
);
`default_nettype wire

// ### tb.sv
/* Self-checking bench for io_port with a pad model on its pins.
   Assumes the register map header, the pad model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "io_port_map.vh"
module tb;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] aux = 16'h0000;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'hFF;
    logic [7:0] sys_out = 8'h00;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, lvttl, irq;
    logic [7:0] pin_in, pin_out, oe_n, pu, pd, slow, ib, reg_en, thr, sys_in;
    logic [3:0] ana, hyst;
    integer seed = 32'h9756c7e8;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    io_port dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .pin_oe_n_o(oe_n), .pull_up_en_o(pu), .pull_down_en_o(pd), .slow_rate_o(slow),
        .in_buf_en_o(ib), .lvttl_sel_o(lvttl), .reg_out_en_o(reg_en), .pair_thr_sel_o(thr),
        .pair_analog_ref_o(ana), .pair_hyst_en_o(hyst), .aux_oe_i(aux),
        .sys_out_i(sys_out), .sys_in_o(sys_in), .port_irq_o(irq)
    );
    pad_model pads (
        .clock_i(clock_i), .pin_out_i(pin_out), .oe_n_i(oe_n), .up_i(pu), .dn_i(pd),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pin_in)
    );
    initial begin
        forever #50 clock_i = ~clock_i;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        do @(posedge clock_i); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("read", rd, e);
    endtask
    task automatic setmode(input logic [2:0] m);
        apb(1'b1, `OFS_DRIVE0, {24'h0, {8{m[0]}}});
        apb(1'b1, `OFS_DRIVE1, {24'h0, {8{m[1]}}});
        apb(1'b1, `OFS_DRIVE2, {24'h0, {8{m[2]}}});
    endtask
    // Packs {input enable, pull-down, pull-up, drive enable low} for one mode on all pins.
    function automatic logic [31:0] drv(input logic [2:0] m, input logic [7:0] d);
        logic [7:0] on;
        on = (m == 3'h6) ? 8'hFF : (m == 3'h4 || m == 3'h2) ? ~d
            : (m == 3'h5 || m == 3'h3) ? d : 8'h00;
        return {(m != 3'h0) ? 8'hFF : 8'h00, (m == 3'h3 || m == 3'h7) ? ~d : 8'h00,
            (m == 3'h2 || m == 3'h7) ? d : 8'h00, ~on};
    endfunction
    function automatic logic [7:0] irq_exp(input logic [15:0] t, input logic [7:0] o,
        input logic [7:0] n);
        for (int b = 0; b < 8; b++) begin
            irq_exp[b] = (t[2*b] & ~o[b] & n[b]) | (t[2*b+1] & o[b] & ~n[b]);
        end
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] e;
        logic [15:0] t;
        int p;
        repeat (3) @(posedge clock_i);
        chk("reset", {ib, pu, pd, oe_n}, 32'h000000FF);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        rdc(`OFS_DRIVE0, 32'h0);
        apb(1'b1, `OFS_EDGE_RATE, 32'hFF);
        for (int m = 0; m < 8; m++) begin
            d = 8'($random(seed));
            setmode(m[2:0]);
            apb(1'b1, `OFS_DATA_OUT, {24'h0, d});
            @(posedge clock_i);
            chk("drive", {ib, pd, pu, oe_n}, drv(m[2:0], d));
            chk("slow", slow, (m > 3 && m < 7) ? 8'hFF : 8'h00);
            chk("data", pin_out, d);
        end
        // Outside drivers let go, so only the pulls of mode 7 set the pad levels.
        ext_en <= 8'h00;
        repeat (3) @(posedge clock_i);
        chk("pulled", sys_in, d);
        ext_en <= 8'hFF;
        apb(1'b1, `OFS_REG_OUT_EN, 32'hFF);
        @(posedge clock_i);
        chk("regout", {reg_en, pu | pd}, 32'hFF00);
        apb(1'b1, `OFS_REG_OUT_EN, 32'h0);
        p = $random(seed) & 7;
        apb(1'b1, `OFS_PIN_VIEW + 12'(4 * p), 32'h19);
        rdc(`OFS_DRIVE0, 32'hFF & ~(32'h1 << p));
        rdc(`OFS_DATA_OUT, {24'h0, d} | (32'h1 << p));
        apb(1'b1, `OFS_DATA_OUT, 32'h0);
        repeat (4) @(posedge clock_i);
        rdc(`OFS_PIN_VIEW + 12'(4 * p), 32'h18);
        setmode(3'h6);
        apb(1'b1, `OFS_BIDIR_EN, 32'hFF);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `OFS_OE_SEL0, s ? 32'hBA98 : 32'h3210);
            apb(1'b1, `OFS_OE_SEL1, s ? 32'hFEDC : 32'h7654);
            repeat (4) begin
                aux <= 16'($random(seed));
                @(posedge clock_i);
                @(posedge clock_i);
                e = ~(s ? aux[15:8] : aux[7:0]);
                chk("bidir", oe_n, e);
            end
        end
        apb(1'b1, `OFS_BIDIR_EN, 32'h0);
        sys_out <= 8'($random(seed));
        apb(1'b1, `OFS_BYPASS, 32'hFF);
        @(posedge clock_i);
        chk("bypass", {pin_out, pin_in}, {sys_out, sys_out});
        apb(1'b1, `OFS_BYPASS, 32'h0);
        setmode(3'h1);
        apb(1'b1, `OFS_INBUF_DIS, 32'hFF);
        ext_val <= 8'($random(seed));
        repeat (4) @(posedge clock_i);
        chk("inbuf", {ib, sys_in}, 32'h0);
        apb(1'b1, `OFS_INBUF_DIS, 32'h0);
        repeat (4) @(posedge clock_i);
        chk("sysin", sys_in, ext_val);
        rdc(`OFS_PIN_STATE, {24'h0, ext_val});
        t = 16'($random(seed));
        apb(1'b1, `OFS_PORT_CFG, 32'h1);
        apb(1'b1, `OFS_SIO_CFG, {16'h0, t});
        @(posedge clock_i);
        chk("lvttl", lvttl, 32'h1);
        for (int k = 0; k < 4; k++) begin
            chk("pair", {hyst[k], ana[k], thr[2*k+:2]}, t[4*k+:4]);
        end
        for (int i = 0; i < 10; i++) begin
            t = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : 16'($random(seed));
            apb(1'b1, `OFS_IRQ_TYPE_LO, {24'h0, t[7:0]});
            apb(1'b1, `OFS_IRQ_TYPE_HI, {24'h0, t[15:8]});
            apb(1'b1, `OFS_IRQ_STATUS, 32'hFF);
            d = 8'($random(seed));
            e = irq_exp(t, ext_val, d);
            ext_val <= d;
            repeat (5) @(posedge clock_i);
            chk("irq", irq, |e);
            rdc(`OFS_IRQ_STATUS, {24'h0, e});
            apb(1'b1, `OFS_IRQ_STATUS, {24'h0, e});
            rdc(`OFS_IRQ_STATUS, 32'h0);
        end
        setmode(3'h6);
        rst_n_i <= 1'b0;
        @(posedge clock_i);
        chk("reset2", {ib, pu, pd, oe_n}, 32'h000000FF);
        rst_n_i <= 1'b1;
        rdc(`OFS_DRIVE0, 32'h0);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("slverr", err, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
